// ---- src/cbb_bridge_regs.v ----
`timescale 1ns/1ps
`include "cbb_map.vh"
module cbb_bridge_regs (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [8:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire cfg_req_in,
  input wire cfg_func_in,
  input wire [7:0] cfg_bus_in,
  output reg cfg_done_out,
  output reg cfg_fwd_out,
  input wire mem_req_in,
  input wire mem_func_in,
  input wire mem_from_card_in,
  input wire [31:0] mem_addr_in,
  output reg mem_done_out,
  output reg mem_fwd_out,
  output reg mem_window_out,
  output reg mem_prefetch_out,
  input wire lat_func_in,
  input wire lat_frame_start_in,
  input wire lat_cycle_in,
  input wire lat_data_phase_in,
  input wire lat_txn_end_in,
  output wire lat_expired_out,
  output wire lat_last_phase_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  function [7:0] be_byte;
    input [7:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    begin
      be_byte = be[0] ? new_v[7:0] : old_v;
    end
  endfunction

  // ----------------------------------------
  // Window slots, base and limit share one
  // ----------------------------------------
  function [1:0] win_slot;
    input f;
    input w;
    begin
      win_slot = {f, w};
    end
  endfunction

  // Low 12 bits never stored, so reads give zero
  function [31:0] win_write;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    begin
      win_write = be_merge(old_v, new_v, be) & `CBB_WIN_MASK;
    end
  endfunction

  // ----------------------------------------
  // Storage, one copy per function
  // ----------------------------------------
  reg [7:0] pri_bus_q [0:1];
  reg [7:0] sec_bus_q [0:1];
  reg [7:0] sub_bus_q [0:1];
  reg [7:0] lat_limit_q [0:1];
  reg [31:0] win_lo_q [0:3];
  // Limits stored with the same 4 KB mask as bases
  reg [31:0] win_hi_q [0:3];
  reg [31:0] brctl_q [0:1];
  reg [7:0] lat_limit_run_q;
  reg [31:0] rdata_d;
  integer i;

  wire [6:0] idx_full;
  wire [5:0] idx;
  wire func;
  wire [1:0] wsel;
  wire req;
  wire wr_go;
  wire [7:0] lat_count;
  wire lat_run;
  wire lat_exp;
  wire lat_last;

  assign idx_full = avs_address_in[8:2];
  assign idx = idx_full[5:0];
  assign func = idx_full[`CBB_FUNC_BIT];
  assign wsel = win_slot(func, idx[1]);
  assign req = avs_read_in || avs_write_in;
  // Write lands on the edge that sees waitrequest low
  assign wr_go = avs_write_in && !avs_waitrequest_out;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state gives read data a flop stage
  // Fixed single wait, so no stall counter is needed
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rdata_d = `CBB_RD_UNMAPPED;
    case (idx)
      `CBB_IDX_PRI_BUS: rdata_d = {24'h000000, pri_bus_q[func]};
      `CBB_IDX_SEC_BUS: rdata_d = {24'h000000, sec_bus_q[func]};
      `CBB_IDX_SUB_BUS: rdata_d = {24'h000000, sub_bus_q[func]};
      `CBB_IDX_LAT: rdata_d = {24'h000000, lat_limit_q[func]};
      `CBB_IDX_WIN0_LO, `CBB_IDX_WIN1_LO: rdata_d = win_lo_q[wsel];
      `CBB_IDX_WIN0_HI, `CBB_IDX_WIN1_HI: rdata_d = win_hi_q[wsel];
      `CBB_IDX_BRCTL: rdata_d = brctl_q[func];
      // Status word is shared by both functions
      `CBB_IDX_LAT_STAT: begin
        rdata_d = {24'h000000, lat_count};
        rdata_d[`CBB_STAT_RUN] = lat_run;
        rdata_d[`CBB_STAT_EXP] = lat_exp;
      end
      default: rdata_d = `CBB_RD_UNMAPPED;
    endcase
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < 2; i = i + 1) begin
        pri_bus_q[i] <= `CBB_BUS_RST;
        sec_bus_q[i] <= `CBB_BUS_RST;
        sub_bus_q[i] <= `CBB_BUS_RST;
        lat_limit_q[i] <= `CBB_LAT_RST;
        brctl_q[i] <= `CBB_BRCTL_RST;
      end
      for (i = 0; i < 4; i = i + 1) begin
        win_lo_q[i] <= `CBB_WIN_RST;
        win_hi_q[i] <= `CBB_WIN_RST;
      end
    end else if (wr_go) begin
      case (idx)
        `CBB_IDX_PRI_BUS: pri_bus_q[func] <=
          be_byte(pri_bus_q[func], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_SEC_BUS: sec_bus_q[func] <=
          be_byte(sec_bus_q[func], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_SUB_BUS: sub_bus_q[func] <=
          be_byte(sub_bus_q[func], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_LAT: lat_limit_q[func] <=
          be_byte(lat_limit_q[func], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_WIN0_LO, `CBB_IDX_WIN1_LO: win_lo_q[wsel] <=
          win_write(win_lo_q[wsel], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_WIN0_HI, `CBB_IDX_WIN1_HI: win_hi_q[wsel] <=
          win_write(win_hi_q[wsel], avs_writedata_in, avs_byteenable_in);
        `CBB_IDX_BRCTL: brctl_q[func] <=
          be_merge(brctl_q[func], avs_writedata_in, avs_byteenable_in)
          & `CBB_BRCTL_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration forwarding
  // ----------------------------------------
  // Result holds until the next lookup request
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_done_out <= 1'b0;
      cfg_fwd_out <= 1'b0;
    end else begin
      cfg_done_out <= cfg_req_in;
      if (cfg_req_in) begin
        cfg_fwd_out <= (cfg_bus_in >= sec_bus_q[cfg_func_in]) &&
          (cfg_bus_in <= sub_bus_q[cfg_func_in]);
      end
    end
  end

  // ----------------------------------------
  // Memory windows
  // ----------------------------------------
  wire [1:0] win_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_win
      wire [1:0] slot;
      // Slot picks this window of the requesting function
      assign slot = win_slot(mem_func_in, g == 1);
      cbb_window_match u_match (
        .base_in(win_lo_q[slot]),
        .limit_in(win_hi_q[slot]),
        .addr_in(mem_addr_in),
        .hit_out(win_hit[g])
      );
    end
  endgenerate

  wire [31:0] mem_brctl;
  assign mem_brctl = brctl_q[mem_func_in];

  // Window 0 wins if both overlap
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_done_out <= 1'b0;
      mem_fwd_out <= 1'b0;
      mem_window_out <= 1'b0;
      mem_prefetch_out <= 1'b0;
    end else begin
      mem_done_out <= mem_req_in;
      if (mem_req_in) begin
        // Card side goes upward only when no window claims it
        // down on hit, up on miss
        mem_fwd_out <= mem_from_card_in ? !(|win_hit) : (|win_hit);
        mem_window_out <= !win_hit[0] && win_hit[1];
        mem_prefetch_out <= win_hit[0] ? mem_brctl[`CBB_BRCTL_PF0] :
          (win_hit[1] && mem_brctl[`CBB_BRCTL_PF1]);
      end
    end
  end

  // ----------------------------------------
  // Latency timer
  // ----------------------------------------
  // Limit follows the function that starts a frame
  // A new limit takes effect at the next frame start
  always @* begin
    lat_limit_run_q = lat_limit_q[lat_func_in];
  end

  cbb_latency_timer u_lat (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .limit_in(lat_limit_run_q),
    .frame_start_in(lat_frame_start_in),
    .cycle_in(lat_cycle_in),
    .data_phase_in(lat_data_phase_in),
    .txn_end_in(lat_txn_end_in),
    .count_out(lat_count),
    .run_out(lat_run),
    .expired_out(lat_exp),
    .last_phase_out(lat_last)
  );

  // Both come straight from timer flops
  assign lat_expired_out = lat_exp;
  assign lat_last_phase_out = lat_last;
endmodule

// ---- src/cbb_map.vh ----
`ifndef CBB_MAP_VH
`define CBB_MAP_VH
// ----------------------------------------
// Register indices, byte address is 4x
// ----------------------------------------
`define CBB_IDX_PRI_BUS 6'h18
`define CBB_IDX_SEC_BUS 6'h19
`define CBB_IDX_SUB_BUS 6'h1a
`define CBB_IDX_LAT 6'h1b
`define CBB_IDX_WIN0_LO 6'h1c
`define CBB_IDX_WIN0_HI 6'h1d
`define CBB_IDX_WIN1_LO 6'h1e
`define CBB_IDX_WIN1_HI 6'h1f
`define CBB_IDX_LAT_STAT 6'h20
`define CBB_IDX_BRCTL 6'h3e
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CBB_FUNC_BIT 6
`define CBB_BUS_RST 8'h00
`define CBB_LAT_RST 8'h00
`define CBB_LAT_MIN_REC 8'h40
`define CBB_WIN_RST 32'h00000000
`define CBB_WIN_MASK 32'hfffff000
`define CBB_WIN_GRAN 32'h00000fff
`define CBB_BRCTL_PF0 8
`define CBB_BRCTL_PF1 9
`define CBB_BRCTL_MASK 32'h00000300
`define CBB_BRCTL_RST 32'h00000000
`define CBB_RD_UNMAPPED 32'h00000000
`define CBB_STAT_RUN 8
`define CBB_STAT_EXP 9
`endif

// ---- src/cbb_window_match.v ----
`timescale 1ns/1ps
module cbb_window_match (
  input wire [31:0] base_in,
  input wire [31:0] limit_in,
  input wire [31:0] addr_in,
  output wire hit_out
);
  wire enabled;
  wire [31:0] top;
  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  // closed at zero
  assign enabled = (base_in != 32'h00000000) || (limit_in != 32'h00000000);
  assign top = limit_in | `CBB_WIN_GRAN;
  assign hit_out = enabled && (addr_in >= base_in) && (addr_in <= top);
endmodule

// ---- src/cbb_latency_timer.v ----
`timescale 1ns/1ps
module cbb_latency_timer (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [7:0] limit_in,
  input wire frame_start_in,
  input wire cycle_in,
  input wire data_phase_in,
  input wire txn_end_in,
  output reg [7:0] count_out,
  output reg run_out,
  output reg expired_out,
  output reg last_phase_out
);
  // ----------------------------------------
  // Counter, ticks once per bus cycle
  // ----------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= 8'h00;
      run_out <= 1'b0;
      expired_out <= 1'b0;
      last_phase_out <= 1'b0;
    end else if (frame_start_in) begin
      count_out <= limit_in;
      run_out <= 1'b1;
      expired_out <= (limit_in == 8'h00);
      last_phase_out <= (limit_in == 8'h00);
    end else if (run_out) begin
      if (txn_end_in || (last_phase_out && data_phase_in)) begin
        run_out <= 1'b0;
        last_phase_out <= 1'b0;
      end else if (cycle_in && count_out != 8'h00) begin
        count_out <= count_out - 8'h01;
        if (count_out == 8'h01) begin
          expired_out <= 1'b1;
          last_phase_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- verification/cbb_bridge_regs_sva.sv ----
`timescale 1ns/1ps
module cbb_bridge_regs_sva (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_out,
  input wire cfg_req_in,
  input wire cfg_done_out,
  input wire cfg_fwd_out,
  input wire mem_req_in,
  input wire mem_done_out,
  input wire lat_data_phase_in,
  input wire lat_expired_out,
  input wire lat_last_phase_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----
  // Handshake and lookups
  // ----
  wait_one_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no answer after one wait");
  wait_rest_a: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  cfg_done_a: assert property (
    cfg_req_in |=> cfg_done_out) else $error("config lookup late");
  cfg_quiet_a: assert property (
    !cfg_req_in |=> !cfg_done_out) else $error("config done unasked");
  fwd_hold_a: assert property (
    !cfg_req_in |=> $stable(cfg_fwd_out)) else $error("fwd moved");
  mem_done_a: assert property (
    mem_req_in |=> mem_done_out) else $error("memory lookup late");
  // ----
  // Latency cut-off
  // ----
  last_clear_a: assert property (
    lat_data_phase_in && lat_last_phase_out |=> !lat_last_phase_out)
    else $error("last phase flag stuck");
  exp_last_a: assert property (
    $rose(lat_expired_out) |-> lat_last_phase_out)
    else $error("expiry without last phase");
endmodule
bind cbb_bridge_regs cbb_bridge_regs_sva i_sva (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .cfg_req_in(cfg_req_in),
  .cfg_done_out(cfg_done_out), .cfg_fwd_out(cfg_fwd_out),
  .mem_req_in(mem_req_in), .mem_done_out(mem_done_out),
  .lat_data_phase_in(lat_data_phase_in),
  .lat_expired_out(lat_expired_out),
  .lat_last_phase_out(lat_last_phase_out)
);

// ---- verification/cbb_card_model.sv ----
`timescale 1ns/1ps
module cbb_card_model (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire slow_in,
  input wire frame_start_in,
  input wire last_phase_in,
  output wire cycle_out,
  output wire data_phase_out,
  output wire txn_end_out
);
  logic busy_q;
  logic [1:0] gap_q;
  logic [2:0] ph_q;
  // ----
  // One initiated burst
  // ----
  // Slow card adds two idle clocks per phase
  assign data_phase_out = busy_q && gap_q == (slow_in ? 2'h2 : 2'h0);
  assign txn_end_out = data_phase_out && (last_phase_in || ph_q == 3'h7);
  assign cycle_out = busy_q;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'h0;
      gap_q <= 2'h0;
      ph_q <= 3'h0;
    end else if (frame_start_in) begin
      busy_q <= 1'h1;
      gap_q <= 2'h0;
      ph_q <= 3'h0;
    end else if (busy_q) begin
      busy_q <= !txn_end_out;
      gap_q <= data_phase_out ? 2'h0 : gap_q + 2'h1;
      ph_q <= ph_q + {2'h0, data_phase_out};
    end
  end
endmodule

// ---- verification/cbb_bridge_regs_tb.sv ----
`timescale 1ns/1ps
module cbb_bridge_regs_tb;
  logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, creq = 1'h0;
  logic cfn = 1'h0, mreq = 1'h0, mcard = 1'h0, fs = 1'h0, lfn = 1'h0;
  logic slow = 1'h0, mfn = 1'h0;
  logic [3:0] be = 4'hf;
  logic [8:0] adr = 9'h000;
  logic [7:0] cbus = 8'h00;
  logic [31:0] wd = 32'h0, maddr = 32'h0, rdq, rdata, v;
  logic waitr, cdone, cfwd, mdone, mfwd, mwin, mpf, lcyc, ldp, lend;
  logic lexp, llast;
  logic [7:0] m [8];
  logic [31:0] wb [8] = '{default: 32'h0};
  int failures = 0, n_checks = 0, i, n;
  cbb_bridge_regs i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitr),
    .cfg_req_in(creq), .cfg_func_in(cfn), .cfg_bus_in(cbus),
    .cfg_done_out(cdone), .cfg_fwd_out(cfwd), .mem_req_in(mreq),
    .mem_func_in(mfn), .mem_from_card_in(mcard), .mem_addr_in(maddr),
    .mem_done_out(mdone), .mem_fwd_out(mfwd), .mem_window_out(mwin),
    .mem_prefetch_out(mpf), .lat_func_in(lfn), .lat_frame_start_in(fs),
    .lat_cycle_in(lcyc), .lat_data_phase_in(ldp), .lat_txn_end_in(lend),
    .lat_expired_out(lexp), .lat_last_phase_out(llast));
  cbb_card_model i_card (.core_clk_in(clk), .rst_n_in(rst_n),
    .slow_in(slow), .frame_start_in(fs), .last_phase_in(llast),
    .cycle_out(lcyc), .data_phase_out(ldp), .txn_end_out(lend));
  always #5 clk = ~clk;
  function logic [8:0] aw(input logic f, input logic [5:0] x);
    return {f, x, 2'h0};
  endfunction
  function logic hit(input logic [31:0] b, input logic [31:0] l,
                     input logic [31:0] a);
    return (b | l) != 32'h0 && b <= a && a <= (l | 32'hfff);
  endfunction
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int k;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitr === 1'h0) break;
    end
    rdq = rdata;
    if (k == 20) begin
      failures++;
      tally_and_finish;
    end
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task cfg(input logic f, input logic [7:0] b, input logic e);
    creq <= 1'h1;
    cfn <= f;
    cbus <= b;
    @(posedge clk);
    creq <= 1'h0;
    @(posedge clk);
    chk({30'h0, cdone, cfwd}, {30'h0, 1'h1, e});
  endtask
  task mem(input logic c, input logic [31:0] a, input logic f);
    logic h0, h1;
    h0 = hit(wb[{f, 2'h0}], wb[{f, 2'h1}], a);
    h1 = hit(wb[{f, 2'h2}], wb[{f, 2'h3}], a);
    mreq <= 1'h1;
    mcard <= c;
    mfn <= f;
    maddr <= a;
    @(posedge clk);
    mreq <= 1'h0;
    @(posedge clk);
    chk({28'h0, mdone, mfwd, mwin, mpf},
        {28'h0, 1'h1, c ^ (h0 | h1), h1 & !h0, h0});
  endtask
  task lat(input logic f, input logic [7:0] l, input logic s, input int e);
    bus(1'h1, aw(f, 6'h1b), {24'h0, l});
    slow <= s;
    lfn <= f;
    fs <= 1'h1;
    @(posedge clk);
    fs <= 1'h0;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      #1;
      if (lexp === 1'h1) break;
    end
    chk(n + 1, e);
    repeat (30) @(posedge clk);
    // Eight fast phases end a 40h frame after seven counts
    bus(1'h0, aw(f, 6'h20), 32'h0);
    chk(rdq, e > 100 ? 32'h39 : 32'h200);
  endtask
  initial begin
    v = $urandom(69928);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (i = 0; i < 16; i++) begin
      bus(1'h0, aw(i[3], 6'h18 + {3'h0, i[2:0]}), 32'h0);
      chk(rdq, 32'h0);
    end
    mem(1'h0, 32'h0, 1'h0);
    mem(1'h1, 32'h0, 1'h1);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      m[i] = v[7:0];
      bus(1'h1, aw(i[2], 6'h18 + {4'h0, i[1:0]}), v);
    end
    for (i = 0; i < 8; i++) begin
      bus(1'h0, aw(i[2], 6'h18 + {4'h0, i[1:0]}), 32'h0);
      chk(rdq, {24'h0, m[i]});
    end
    bus(1'h1, 9'h0fc, 32'hffffffff);
    bus(1'h0, 9'h0fc, 32'h0);
    chk(rdq, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = i[0] ? $urandom : 32'hffffffff;
      bus(1'h1, aw(1'h1, 6'h1c + {4'h0, i[1], 1'h0}), v);
      bus(1'h0, aw(1'h1, 6'h1c + {4'h0, i[1], 1'h0}), 32'h0);
      chk(rdq, v & 32'hfffff000);
      wb[{1'h1, i[1], 1'h0}] = v & 32'hfffff000;
    end
    be <= 4'h4;
    bus(1'h1, aw(1'h1, 6'h1c), 32'hffffffff);
    be <= 4'hf;
    wb[4] = wb[4] | 32'h00ff0000;
    bus(1'h0, aw(1'h1, 6'h1c), 32'h0);
    chk(rdq, wb[4]);
    $display("register access done");
    bus(1'h1, aw(1'h0, 6'h19), 32'h5);
    bus(1'h1, aw(1'h0, 6'h1a), 32'h9);
    bus(1'h1, aw(1'h1, 6'h19), 32'h5);
    bus(1'h1, aw(1'h1, 6'h1a), 32'h6);
    for (i = 0; i < 32; i++) begin
      v = i < 16 ? 32'h3 + i / 2 : $urandom & 32'hf;
      cfg(i[0], v[7:0], v >= 32'h5 && v <= (i[0] ? 32'h6 : 32'h9));
    end
    wb[0] = 32'h10000;
    wb[1] = 32'h1ffff;
    wb[2] = 32'h30000;
    wb[3] = 32'h3ffff;
    for (i = 0; i < 4; i++)
      bus(1'h1, aw(1'h0, 6'h1c + i[5:0]), wb[i]);
    bus(1'h1, aw(1'h0, 6'h3e), 32'h100);
    for (i = 0; i < 18; i++) begin
      v = i < 12 ? 32'hfff + 32'h10000 * (i / 2) : $urandom & 32'h3ffff;
      mem(i[0], v, i >= 14);
    end
    $display("lookups done");
    lat(1'h0, 8'h00, 1'h0, 1);
    lat(1'h1, 8'h03, 1'h1, 3);
    lat(1'h0, 8'h40, 1'h0, 101);
    for (i = 0; i < 4; i++) begin
      v = 32'h1 + $urandom % 6;
      lat(i[0], v[7:0], i[1], v);
    end
    $display("latency done");
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    bus(1'h0, aw(1'h1, 6'h1b), 32'h0);
    chk(rdq, 32'h0);
    bus(1'h0, aw(1'h1, 6'h1c), 32'h0);
    chk(rdq, 32'h0);
    $display("second reset done");
    tally_and_finish;
  end
endmodule
